// ---- logic/panel_seq_consts.svh ----
// Purpose: constants of the panel update power sequencer
// Assumes: 100 MHz core clock, AHB-Lite register bus
// Notes: times in ns, cycle counts derived below
// Operation
// - power-up in standby runs oscillator start-up, then power-stable period
// - flash disabled: ignore waveform select, use the loaded waveform
// - standalone: each update command in stable runs one update, returns to stable
// - stable period accepts segment length, next segment data, panel power (0C,10,20)
// - stable period accepts panel drive, temp sense on, waveform load (21,23,0A)
// - stable period accepts display update 13 and power-down 12
// - power-down in stable enters falling period, then standby
// - flash on, auto temp off: use waveform select bits twelve to ten
// - flash on, auto temp on: choose waveform from temperature result
// - high secondary select pin switches to expansion operation
// - expansion update start timed from trigger and base clock
// - expansion use treats display update command as invalid; code takes it, starts no update, does not count it ignored
// - expansion: return to stable after update, repeat on every trigger
// - slave takes trigger and base clock from the master device
`ifndef PANEL_SEQ_CONSTS_SVH
`define PANEL_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define OSC_START_NS 2000
`define FALL_NS 1000
`define UPDATE_NS 50000
`define OSC_START_CYC ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FALL_CYC ((`FALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UPDATE_CYC ((`UPDATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXP_UPDATE_EDGES 32
`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08
`define REG_PARAM 8'h0C
`define CFG_RESET 32'h0000_0000
`define CFG_FLASH_DIS_BIT 0
`define CFG_EXP_MODE_BIT 1
`define CFG_AUTO_TEMP_BIT 2
`define CFG_WSEL_LSB 10
`define CMD_POWER_UP 8'h04
`define CMD_WAVE_LOAD 8'h0A
`define CMD_SEG_LEN 8'h0C
`define CMD_NEXT_SEG 8'h10
`define CMD_POWER_DOWN 8'h12
`define CMD_UPDATE 8'h13
`define CMD_PANEL_POWER 8'h20
`define CMD_PANEL_DRIVE 8'h21
`define CMD_TEMP_SENSE 8'h23
`endif

// ---- logic/panel_seq_pkg.sv ----
// Purpose: types of the panel update power sequencer
// Assumes: nothing
// Notes: one-hot state codes
package panel_seq_pkg;
    typedef enum logic [4:0] {
        ST_STANDBY = 5'h01,
        ST_OSC = 5'h02,
        ST_STABLE = 5'h04,
        ST_UPDATE = 5'h08,
        ST_FALL = 5'h10
    } seq_state_type;
endpackage

// ---- logic/panel_update_power_sequencer.sv ----
// Purpose: command-driven power and update sequencer behind an AHB-Lite slave
// Assumes: single word transfers, zero wait states
// Notes: link pins are sampled by CLK_IN through two flops
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "panel_seq_consts.svh"
module panel_update_power_sequencer #(
    parameter int OSC_CYC = `OSC_START_CYC,
    parameter int FALL_CYC = `FALL_CYC,
    parameter int UPDATE_CYC = `UPDATE_CYC,
    parameter int EXP_EDGES = `EXP_UPDATE_EDGES
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic SECONDARY_SELECT_IN,
    input wire logic UPDATE_START_TRIGGER_IN,
    input wire logic UPDATE_BASE_CLOCK_IN,
    input wire logic [2:0] TEMP_WAVE_IN,
    output logic OSC_RUN_OUT,
    output logic UPDATE_ACTIVE_OUT,
    output logic [2:0] WAVE_SEL_OUT,
    output logic WAVE_FROM_FLASH_OUT,
    output panel_seq_pkg::seq_state_type STATE_OUT
);
    import panel_seq_pkg::*;

    if (OSC_CYC < 1 || OSC_CYC > 65535 || FALL_CYC < 1 || FALL_CYC > 65535 ||
        UPDATE_CYC < 1 || UPDATE_CYC > 65535 || EXP_EDGES < 1 || EXP_EDGES > 65535) begin : g_bad
        $error("counts must lie in 1..65535");
    end

    seq_state_type state;
    logic [15:0] cnt;
    logic [31:0] cfg;
    logic [7:0] seg_len, next_seg, panel_power, panel_drive, wave_loaded;
    logic [2:0] temp_wave;
    logic [7:0] update_count, ignored_count;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic sel_s1, sel_s2;
    logic trg_s1, trg_s2, trg_s3;
    logic bck_s1, bck_s2, bck_s3;

    // ---- pin synchronisers; first flop feeds only the second
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_s3 <= 1'b0;
            bck_s1 <= 1'b0;
            bck_s2 <= 1'b0;
            bck_s3 <= 1'b0;
        end else begin
            sel_s1 <= SECONDARY_SELECT_IN;
            sel_s2 <= sel_s1;
            trg_s1 <= UPDATE_START_TRIGGER_IN;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
            bck_s1 <= UPDATE_BASE_CLOCK_IN;
            bck_s2 <= bck_s1;
            bck_s3 <= bck_s2;
        end
    end

    logic expansion, trg_rise, bck_rise;
    assign expansion = sel_s2;
    assign trg_rise = trg_s2 && !trg_s3;
    assign bck_rise = bck_s2 && !bck_s3;

    // ---- AHB-Lite slave, always ready, always OKAY
    logic addr_ok;
    assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && HWRITE_IN;
            wr_addr <= HADDR_IN[7:0];
        end
    end

    logic [31:0] status_word;
    assign status_word = {ignored_count, update_count, 5'h00, WAVE_SEL_OUT,
                          1'b0, WAVE_FROM_FLASH_OUT, expansion, state};

    // read data sampled in the address phase; unmapped words read zero
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            HRDATA_OUT <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE_IN) begin
            case (HADDR_IN[7:0])
                `REG_CFG: HRDATA_OUT <= cfg;
                `REG_STATUS: HRDATA_OUT <= status_word;
                `REG_PARAM: HRDATA_OUT <= {panel_drive, panel_power, next_seg, seg_len};
                default: HRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // ---- command decode
    logic cmd_valid, known_cmd, in_stable, in_standby;
    logic power_up, power_down, update_go, take_cmd;
    logic [7:0] code, param;
    assign code = HWDATA_IN[7:0];
    assign param = HWDATA_IN[15:8];
    assign cmd_valid = wr_pend && wr_addr == `REG_CMD;
    assign in_stable = state == ST_STABLE;
    assign in_standby = state == ST_STANDBY;
    always_comb begin
        case (code)
            `CMD_SEG_LEN, `CMD_NEXT_SEG, `CMD_PANEL_POWER: known_cmd = 1'b1;
            `CMD_PANEL_DRIVE, `CMD_TEMP_SENSE, `CMD_WAVE_LOAD: known_cmd = 1'b1;
            `CMD_UPDATE, `CMD_POWER_DOWN: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
    end
    assign take_cmd = cmd_valid && in_stable && known_cmd;
    assign power_up = cmd_valid && in_standby && code == `CMD_POWER_UP;
    assign power_down = take_cmd && code == `CMD_POWER_DOWN;
    // power-down wins over a trigger seen in the same cycle
    assign update_go = in_stable && !power_down &&
        (expansion ? trg_rise : (take_cmd && code == `CMD_UPDATE));

    // ---- sequencer
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            state <= ST_STANDBY;
            cnt <= 16'h0000;
        end else begin
            case (state)
                ST_STANDBY: begin
                    if (power_up) begin
                        state <= ST_OSC;
                        cnt <= 16'(OSC_CYC - 1);
                    end
                end
                ST_OSC: begin
                    if (cnt == 16'h0000) begin
                        state <= ST_STABLE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                ST_STABLE: begin
                    if (power_down) begin
                        state <= ST_FALL;
                        cnt <= 16'(FALL_CYC - 1);
                    end else if (update_go) begin
                        state <= ST_UPDATE;
                        cnt <= expansion ? 16'(EXP_EDGES - 1) : 16'(UPDATE_CYC - 1);
                    end
                end
                ST_UPDATE: begin
                    // expansion length counted in base clock edges
                    if (!expansion || bck_rise) begin
                        if (cnt == 16'h0000) begin
                            state <= ST_STABLE;
                        end else begin
                            cnt <= cnt - 16'h0001;
                        end
                    end
                end
                ST_FALL: begin
                    if (cnt == 16'h0000) begin
                        state <= ST_STANDBY;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_STANDBY;
                    cnt <= 16'h0000;
                end
            endcase
        end
    end

    // ---- configuration, only in standby
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            cfg <= `CFG_RESET;
        end else if (wr_pend && wr_addr == `REG_CFG && in_standby) begin
            cfg <= HWDATA_IN;
        end
    end

    // ---- command parameters; waveform load also allowed in standby
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            seg_len <= 8'h00;
            next_seg <= 8'h00;
            panel_power <= 8'h00;
            panel_drive <= 8'h00;
            wave_loaded <= 8'h00;
            temp_wave <= 3'h0;
        end else begin
            if (take_cmd && code == `CMD_SEG_LEN) begin
                seg_len <= param;
            end
            if (take_cmd && code == `CMD_NEXT_SEG) begin
                next_seg <= param;
            end
            if (take_cmd && code == `CMD_PANEL_POWER) begin
                panel_power <= param;
            end
            if (take_cmd && code == `CMD_PANEL_DRIVE) begin
                panel_drive <= param;
            end
            if (take_cmd && code == `CMD_TEMP_SENSE) begin
                temp_wave <= TEMP_WAVE_IN;
            end
            if ((take_cmd || (cmd_valid && in_standby)) && code == `CMD_WAVE_LOAD) begin
                wave_loaded <= param;
            end
        end
    end

    // ---- waveform choice, frozen for the whole update
    logic flash_dis, auto_temp;
    assign flash_dis = cfg[`CFG_FLASH_DIS_BIT];
    assign auto_temp = cfg[`CFG_AUTO_TEMP_BIT];
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            WAVE_SEL_OUT <= 3'h0;
            WAVE_FROM_FLASH_OUT <= 1'b0;
        end else if (update_go) begin
            if (flash_dis) begin
                WAVE_SEL_OUT <= wave_loaded[2:0];
                WAVE_FROM_FLASH_OUT <= 1'b0;
            end else if (auto_temp) begin
                WAVE_SEL_OUT <= temp_wave;
                WAVE_FROM_FLASH_OUT <= 1'b1;
            end else begin
                WAVE_SEL_OUT <= cfg[`CFG_WSEL_LSB +: 3];
                WAVE_FROM_FLASH_OUT <= 1'b1;
            end
        end
    end

    // ---- counters seen by software, wrap at 255
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            update_count <= 8'h00;
            ignored_count <= 8'h00;
        end else begin
            if (update_go) begin
                update_count <= update_count + 8'h01;
            end
            if (cmd_valid && !take_cmd && !power_up &&
                !(in_standby && code == `CMD_WAVE_LOAD)) begin
                ignored_count <= ignored_count + 8'h01;
            end
        end
    end

    assign STATE_OUT = state;
    assign OSC_RUN_OUT = !in_standby;
    assign UPDATE_ACTIVE_OUT = state == ST_UPDATE;

    // ---- checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_osc_entry: assert property (in_standby && power_up |=> state == ST_OSC ##0 cnt == 16'(OSC_CYC - 1))
        else $error("power-up did not start oscillator period");
    a_osc_exit: assert property (state == ST_OSC && cnt == 16'h0000 |=> in_stable)
        else $error("oscillator period did not end in stable");
    a_flash_off: assert property (update_go && flash_dis |=> !WAVE_FROM_FLASH_OUT
        && WAVE_SEL_OUT == $past(wave_loaded[2:0]))
        else $error("loaded waveform not used");
    a_cmd_update: assert property (in_stable && !expansion && take_cmd && code == `CMD_UPDATE
        |=> state == ST_UPDATE)
        else $error("update command did not start update");
    a_update_return: assert property ($fell(state == ST_UPDATE) |-> in_stable)
        else $error("update did not return to stable");
    a_param_store: assert property (take_cmd && code == `CMD_PANEL_DRIVE
        |=> panel_drive == $past(param) ##1 panel_drive == $past(param, 2))
        else $error("accepted parameter not held");
    a_power_down: assert property (in_stable && cmd_valid && code == `CMD_POWER_DOWN
        |=> state == ST_FALL)
        else $error("power-down did not enter falling");
    a_fall_exit: assert property (state == ST_FALL && cnt == 16'h0000 |=> in_standby)
        else $error("falling period did not end in standby");
    a_flash_select: assert property (update_go && !flash_dis && !auto_temp
        |=> WAVE_FROM_FLASH_OUT && WAVE_SEL_OUT == $past(cfg[12:10]))
        else $error("selected flash waveform not used");
    a_auto_temp: assert property (update_go && !flash_dis && auto_temp
        |=> WAVE_SEL_OUT == $past(temp_wave))
        else $error("temperature waveform not used");
    a_exp_cmd_void: assert property (in_stable && expansion && !trg_rise && cmd_valid
        && code == `CMD_UPDATE |=> in_stable)
        else $error("update command acted in expansion use");
    a_exp_trigger: assert property (in_stable && expansion && trg_rise && !power_down
        |=> state == ST_UPDATE)
        else $error("trigger did not start update");
    a_unknown_cmd: assert property (in_stable && cmd_valid && !known_cmd
        |=> in_stable && $stable(seg_len) && $stable(panel_drive))
        else $error("unknown command changed state");
    a_update_source: assert property ($rose(UPDATE_ACTIVE_OUT) |-> $past(state) == ST_STABLE)
        else $error("update started outside stable");

    // timing and freeze checks; expansion length counts base clock edges, not core cycles
    a_update_len: assert property (update_go && !expansion
        |=> state == ST_UPDATE ##0 cnt == 16'(UPDATE_CYC - 1))
        else $error("standalone update length not loaded");
    a_exp_len: assert property (update_go && expansion
        |=> state == ST_UPDATE ##0 cnt == 16'(EXP_EDGES - 1))
        else $error("expansion update length not loaded");
    a_exp_hold: assert property (state == ST_UPDATE && expansion && !bck_rise
        |=> state == ST_UPDATE && $stable(cnt))
        else $error("expansion update moved without base clock edge");
    a_standby_hold: assert property (in_standby && !power_up
        |=> in_standby)
        else $error("standby left without power-up");
    a_wave_frozen: assert property (state == ST_UPDATE
        |=> $stable(WAVE_SEL_OUT) && $stable(WAVE_FROM_FLASH_OUT))
        else $error("waveform changed during update");
    a_count_step: assert property (update_go
        |=> update_count == $past(update_count) + 8'h01)
        else $error("update not counted");
    a_cfg_locked: assert property (!in_standby
        |=> $stable(cfg))
        else $error("configuration changed outside standby");
    a_osc_hold: assert property (state == ST_OSC && cnt != 16'h0000
        |=> state == ST_OSC && cnt == $past(cnt) - 16'h0001)
        else $error("oscillator period cut short");
    a_outside_idle: assert property (!in_stable && state != ST_UPDATE
        |=> !UPDATE_ACTIVE_OUT)
        else $error("update active from outside stable");
endmodule

// ---- test/ext_ctrl_model.sv ----
// Purpose: far-side controller model, makes the update trigger and base clock
// Assumes: sequencer counts base clock rising edges after the trigger edge
// Notes: base clock stands still between frames, two spare edges per frame
`timescale 1ns/1ps
module ext_ctrl_model #(
    parameter int EDGES = 3
) (
    input wire logic go_in,
    output logic trig_out,
    output logic bclk_out
);
    initial begin
        trig_out = 1'b0;
        bclk_out = 1'b0;
    end
    // odd offset keeps the link out of phase with the core clock
    always @(posedge go_in) begin
        #3.7 trig_out = 1'b1;
        repeat (EDGES + 2) begin
            #62.5 bclk_out = 1'b1;
            #62.5 bclk_out = 1'b0;
        end
        trig_out = 1'b0;
    end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for the panel update power sequencer
// Assumes: zero wait-state slave, long counts shortened by parameter
// Notes: results are seen by reading status and parameters over the bus
`timescale 1ns/1ps
`include "panel_seq_consts.svh"
module tb;
    import panel_seq_pkg::*;
    localparam int OSC = 5;
    localparam int FALL = 4;
    localparam int UPD = 10;
    localparam int EXP = 3;
    typedef struct {logic [31:0] val; logic [31:0] mask;} note_type;
    note_type notes[$];
    note_type cur;
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0, sel_pin = 1'b0, go = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [2:0] temp = 3'h0, w, t;
    logic [7:0] p[4];
    logic [4:0] exp_s = 5'h00;
    logic [3:0] exp_w = 4'h0;
    logic s_pend = 1'b0, w_pend = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, trig, bclk;
    wire logic osc_run, upd_act, wave_f;
    wire logic [2:0] wave_s;
    wire logic [4:0] state_o;
    int num_errors = 0, n_checks = 0, n_upd = 0, n_ign = 0;
    always #5 clk = ~clk;
    panel_update_power_sequencer #(.OSC_CYC(OSC), .FALL_CYC(FALL), .UPDATE_CYC(UPD), .EXP_EDGES(EXP)) u_dut (
        .CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .SECONDARY_SELECT_IN(sel_pin),
        .UPDATE_START_TRIGGER_IN(trig), .UPDATE_BASE_CLOCK_IN(bclk), .TEMP_WAVE_IN(temp), .OSC_RUN_OUT(osc_run),
        .UPDATE_ACTIVE_OUT(upd_act), .WAVE_SEL_OUT(wave_s), .WAVE_FROM_FLASH_OUT(wave_f), .STATE_OUT(state_o));
    ext_ctrl_model #(.EDGES(EXP)) u_ctrl (.go_in(go), .trig_out(trig), .bclk_out(bclk));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // monitor: each read data phase retires the oldest note
    always @(posedge clk) begin
        if (rd_phase && hready === 1'b1) begin
            cur = notes.pop_front();
            check(hrdata & cur.mask, cur.val);
            check({31'h0, hresp}, 32'h0);
        end
    end
    // direct pins, looked at mid-cycle where they stand
    always @(negedge clk) begin
        if (s_pend) begin
            s_pend = 1'b0;
            check({27'h0, state_o}, {27'h0, exp_s});
            check({31'h0, osc_run}, {31'h0, exp_s != ST_STANDBY});
            check({31'h0, upd_act}, {31'h0, exp_s == ST_UPDATE});
        end
        if (w_pend) begin
            w_pend = 1'b0;
            check({28'h0, wave_f, wave_s}, {28'h0, exp_w});
        end
    end
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: bus hang", $time);
            wrap_up();
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !wr;
        wait_rdy();
        rd_phase <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] code);
        xfer(1'b1, `REG_CMD, {16'h0, 8'h00, code});
    endtask
    task automatic prm(input logic [7:0] code, input logic [7:0] v);
        xfer(1'b1, `REG_CMD, {16'h0, v, code});
    endtask
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{v, m});
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic state_is(input logic [4:0] s);
        exp_s = s;
        s_pend = 1'b1;
        expect_rd(`REG_STATUS, {27'h0, s}, 32'h0000_001F);
    endtask
    task automatic counts();
        expect_rd(`REG_STATUS, {8'(n_ign), 8'(n_upd), 16'h0}, 32'hFFFF_0000);
    endtask
    task automatic gap(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic pwr_up();
        cmd(`CMD_POWER_UP);
        state_is(ST_OSC);
        gap(OSC);
        state_is(ST_STABLE);
    endtask
    task automatic pwr_down();
        cmd(`CMD_POWER_DOWN);
        state_is(ST_FALL);
        gap(FALL);
        state_is(ST_STANDBY);
    endtask
    // wave source is frozen at update start, so read it while updating
    task automatic update(input logic f, input logic [2:0] ws, input logic [31:0] m);
        cmd(`CMD_UPDATE);
        exp_w = {f, ws};
        w_pend = 1'b1;
        state_is(ST_UPDATE);
        expect_rd(`REG_STATUS, {21'h0, ws, 1'b0, f, 6'h0}, m);
        gap(UPD);
        state_is(ST_STABLE);
        n_upd++;
    endtask
    initial begin
        void'($urandom(57));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        state_is(ST_STANDBY);
        counts();
        expect_rd(`REG_CFG, `CFG_RESET, 32'hFFFF_FFFF);
        expect_rd(8'h10, 32'h0, 32'hFFFF_FFFF);
        $display("test reset done");
        w = 3'($urandom);
        xfer(1'b1, `REG_CFG, 32'h1 | (32'(w) << `CFG_WSEL_LSB));
        prm(`CMD_WAVE_LOAD, 8'h05);
        pwr_up();
        foreach (p[i]) p[i] = 8'($urandom);
        prm(`CMD_SEG_LEN, p[0]);
        prm(`CMD_NEXT_SEG, p[1]);
        prm(`CMD_PANEL_POWER, p[2]);
        prm(`CMD_PANEL_DRIVE, p[3]);
        // loaded waveform differs from the select field, so a wrong source shows
        prm(`CMD_WAVE_LOAD, {5'h0, ~w});
        expect_rd(`REG_PARAM, {p[3], p[2], p[1], p[0]}, 32'hFFFF_FFFF);
        update(1'b0, ~w, 32'h0000_0740);
        update(1'b0, ~w, 32'h0000_0740);
        prm(8'h55, 8'hAA);
        n_ign++;
        xfer(1'b1, `REG_CFG, 32'h0);
        state_is(ST_STABLE);
        expect_rd(`REG_PARAM, {p[3], p[2], p[1], p[0]}, 32'hFFFF_FFFF);
        expect_rd(`REG_CFG, 32'h1 | (32'(w) << `CFG_WSEL_LSB), 32'hFFFF_FFFF);
        counts();
        pwr_down();
        $display("test standalone loaded done");
        w = 3'($urandom);
        xfer(1'b1, `REG_CFG, 32'(w) << `CFG_WSEL_LSB);
        pwr_up();
        update(1'b1, w, 32'h0000_0740);
        pwr_down();
        t = w ^ 3'($urandom_range(7, 1));
        xfer(1'b1, `REG_CFG, 32'h4 | (32'(w) << `CFG_WSEL_LSB));
        pwr_up();
        temp <= t;
        cmd(`CMD_TEMP_SENSE);
        update(1'b1, t, 32'h0000_0740);
        pwr_down();
        $display("test flash done");
        xfer(1'b1, `REG_CFG, 32'h3);
        sel_pin <= 1'b1;
        pwr_up();
        expect_rd(`REG_STATUS, 32'h20, 32'h20);
        // accepted code in stable, dropped by expansion use, so not counted
        cmd(`CMD_UPDATE);
        state_is(ST_STABLE);
        repeat (2) begin
            go <= 1'b1;
            gap(8);
            state_is(ST_UPDATE);
            go <= 1'b0;
            gap(80);
            state_is(ST_STABLE);
            n_upd++;
        end
        counts();
        pwr_down();
        $display("test expansion done");
        xfer(1'b1, `REG_CFG, 32'h1);
        expect_rd(`REG_CFG, 32'h1, 32'hFFFF_FFFF);
        go <= 1'b1;
        gap(80);
        state_is(ST_STANDBY);
        sel_pin <= 1'b0;
        gap(4);
        cmd(`CMD_UPDATE);
        n_ign++;
        state_is(ST_STANDBY);
        counts();
        $display("test outside stable done");
        wrap_up();
    end
endmodule
